// ---- inc/pxr_pkg.sv ----
/*
  pxr_pkg: register selects, field positions, reset values and state encodings
  for the exception and mode register bank.
  assumes: included before every file of the bank; no other dependencies.
*/
package pxr_pkg;

  // ****************************************************************
  // register selects on the internal register move port
  // ****************************************************************
  localparam logic [2:0] SEL_EXC_RET   = 3'h0;
  localparam logic [2:0] SEL_IRQ_CLR   = 3'h1;
  localparam logic [2:0] SEL_SER_RCV   = 3'h2;
  localparam logic [2:0] SEL_TB_FULL   = 3'h3;
  localparam logic [2:0] SEL_TB_NONGLB = 3'h4;
  localparam logic [2:0] SEL_TB_SINGLE = 3'h5;
  localparam logic [2:0] SEL_MODE      = 3'h6;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FW_MODE_BIT   = 0;
  localparam int ADJ_BIT       = 1;
  localparam int CORR_CLR_BIT  = 0;
  localparam int CNT0_CLR_BIT  = 8;
  localparam int CNT1_CLR_BIT  = 15;
  localparam int SER_CLR_BIT   = 32;
  localparam int RX_LVL_BIT    = 3;
  localparam int CM_WR_LO      = 3;
  localparam int CM_RD_LO      = 1;
  localparam int CM_RD_HI      = 34;

  // ****************************************************************
  // sizes, reset values and fixed figures
  // ****************************************************************
  localparam int          TB_ENTRIES   = 12;
  localparam logic [63:0] EXC_RET_RST  = 64'h0000_0000_0000_0001;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [63:0] PC_STEP      = 64'h0000_0000_0000_0004;

  // ****************************************************************
  // return sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    RS_IDLE   = 3'b001,
    RS_JUMP   = 3'b010,
    RS_WAIT   = 3'b100
  } pxr_ret_e;

endpackage : pxr_pkg

// ---- inc/pxr_tb_if.sv ----
/*
  pxr_tb_if: invalidate commands from the register bank to the translation
  buffer valid array.
  assumes: both ends run on the same clock.
*/
`timescale 1ns/10ps
interface pxr_tb_if;
  logic                           inv_all;
  logic                           inv_nonglobal;
  logic [pxr_pkg::TB_ENTRIES-1:0] fill_valid;
  logic [pxr_pkg::TB_ENTRIES-1:0] fill_glob;
  logic [pxr_pkg::TB_ENTRIES-1:0] valid;
  logic [pxr_pkg::TB_ENTRIES-1:0] glob;
  logic [1:0]                     ptr_rst;
  modport ctl (output inv_all, inv_nonglobal, fill_valid, fill_glob,
               input valid, glob, ptr_rst);
  modport arr (input inv_all, inv_nonglobal, fill_valid, fill_glob,
               output valid, glob, ptr_rst);
endinterface : pxr_tb_if

// ---- src/pxr_tb_valid.sv ----
/*
  pxr_tb_valid: valid and address-space-match bits of the twelve instruction
  translation buffer entries, plus the two not-last-used pointer resets.
  assumes: fill strobes come from the translation fill path of the core.
*/
`timescale 1ns/10ps
module pxr_tb_valid (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  pxr_tb_if.arr     tb
);

  logic [1:0] ptr_rst_q;

  // ****************************************************************
  // per entry valid bit
  // ****************************************************************
  for (genvar e = 0; e < pxr_pkg::TB_ENTRIES; e++) begin : g_ent
    logic v_q;
    logic g_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        v_q <= 1'b0;
        g_q <= 1'b0;
      end else if (ce_i) begin
        if (tb.inv_all) begin
          v_q <= 1'b0;
        end else if (tb.inv_nonglobal && !g_q) begin
          v_q <= 1'b0;
        end else if (tb.fill_valid[e]) begin
          v_q <= 1'b1;
          g_q <= tb.fill_glob[e];
        end
      end
    end
    assign tb.valid[e] = v_q;
    assign tb.glob[e]  = g_q;
  end

  // pointer reset is a pulse for both replacement pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_rst_q <= 2'h0;
    end else if (ce_i) begin
      ptr_rst_q <= {2{tb.inv_all}};
    end
  end
  assign tb.ptr_rst = ptr_rst_q;

  property p_glob_survives;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && tb.inv_nonglobal && !tb.inv_all && tb.valid[0] && tb.glob[0])
      |=> tb.valid[0];
  endproperty
  a_glob_survives: assert property (p_glob_survives) else $error("global entry lost");

endmodule : pxr_tb_valid

// ---- src/pxr_ser_rx.sv ----
/*
  pxr_ser_rx: serial receive level and transition detection on the serial rom
  data pin once the cache load has finished.
  assumes: pin is synchronous to clk_i.
*/
`timescale 1ns/10ps
module pxr_ser_rx (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic loaded_i,
  input  wire logic serial_rom_data_pin_i,
  output logic      rx_lvl_o,
  output logic      edge_o
);

  logic rx_lvl_q;
  logic armed_q;

  // ****************************************************************
  // level capture
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_lvl_q <= 1'b0;
      armed_q  <= 1'b0;
    end else if (ce_i) begin
      armed_q <= loaded_i;
      if (loaded_i) begin
        rx_lvl_q <= serial_rom_data_pin_i;
      end
    end
  end

  assign rx_lvl_o = rx_lvl_q;
  // first sample after load is not a transition, so no false request
  assign edge_o = ce_i && armed_q && loaded_i && (serial_rom_data_pin_i != rx_lvl_q);

endmodule : pxr_ser_rx

// ---- src/pxr_regs.sv ----
/*
  pxr_regs: exception return address, interrupt request clear, serial receive,
  translation buffer invalidate strobes and current mode registers.
  assumes: one move instruction per cycle; fetch and exception sources are
  single-cycle pulses from the instruction unit; inputs synchronous to clk_i.
*/
// Contract
// - return instruction jumps to saved address
// - saved address moves both ways, hardware writes
// - exception saves address of unfinished instruction
// - bit 0 selects firmware mode on return
// - firmware call saves following instruction address
// - traps flag bit 1: 0 means four high
// - other entries leave bit 1 clear
// - clear register write-only, four clear bits
// - writing zero clears that pending request
// - counter 0 and 1 cleared separately
// - bit 32 clears serial line request
// - one bit clears correctable read error
// - receive bit 3 follows data pin
// - receive transition sets serial line request
// - serial request gated by enable bit
// - full invalidate clears all, resets pointers
// - single invalidate behaves as full invalidate
// - nonglobal invalidate clears match-zero entries only
// - mode written bits 4:3, read 34,1
`timescale 1ns/10ps
module pxr_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // internal register move port
  input  wire logic        mtpr_i,
  input  wire logic        mfpr_i,
  input  wire logic [2:0]  sel_i,
  input  wire logic [63:0] wdata_i,
  output logic [63:0]      rdata_o,
  output logic             rvalid_o,
  // exception entry from the instruction unit
  input  wire logic        exc_i,
  input  wire logic        exc_call_i,
  input  wire logic        exc_trap_i,
  input  wire logic        exc_adj_ok_i,
  input  wire logic [63:0] exc_pc_i,
  // return from exception
  input  wire logic        rei_i,
  output logic             rei_jump_o,
  output logic [63:0]      rei_target_o,
  output logic             rei_fw_mode_o,
  // interrupt request sources and enable
  input  wire logic        cnt0_ovf_i,
  input  wire logic        cnt1_ovf_i,
  input  wire logic        corr_err_i,
  input  wire logic        serial_line_enable_bit_i,
  output logic             ser_req_o,
  output logic             cnt0_req_o,
  output logic             cnt1_req_o,
  output logic             corr_req_o,
  output logic             ser_irq_o,
  // serial rom pin
  input  wire logic        icache_loaded_i,
  input  wire logic        serial_rom_data_pin_i,
  // translation buffer fill and state
  input  wire logic [11:0] tb_fill_i,
  input  wire logic [11:0] tb_fill_glob_i,
  output logic [11:0]      tb_valid_o,
  output logic [1:0]       ptr_rst_o,
  output logic [1:0]       cur_mode_o
);

  logic [63:0]       exc_ret_q;
  logic              ser_req_q;
  logic              cnt0_req_q;
  logic              cnt1_req_q;
  logic              corr_req_q;
  logic [1:0]        mode_q;
  logic [63:0]       rdata_q;
  logic              rvalid_q;
  logic              jump_q;
  logic [63:0]       tgt_q;
  logic              fwm_q;
  logic              rx_lvl;
  logic              ser_edge;
  logic              clr_wr;
  logic [63:0]       exc_val;
  logic [63:0]       rd_mux;
  pxr_pkg::pxr_ret_e rs_q;
  pxr_tb_if tbi ();

  // ****************************************************************
  // exception return address
  // ****************************************************************
  always_comb begin
    exc_val = {exc_pc_i[63:2], 2'h0};
    if (exc_trap_i) begin
      exc_val[pxr_pkg::ADJ_BIT] = exc_adj_ok_i;
    end
    exc_val[pxr_pkg::FW_MODE_BIT] = 1'b1;  // every entry sets bit 0, so the following return runs in firmware mode
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_ret_q <= pxr_pkg::EXC_RET_RST;
    end else if (ce_i) begin
      // hardware entry beats a software move in the same cycle
      if (exc_i) begin
        exc_ret_q <= exc_val;
      end else if (mtpr_i && sel_i == pxr_pkg::SEL_EXC_RET) begin
        exc_ret_q <= wdata_i;
      end
    end
  end

  // ****************************************************************
  // return sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_q   <= pxr_pkg::RS_IDLE;
      jump_q <= 1'b0;
      tgt_q  <= 64'h0;
      fwm_q  <= 1'b1;
    end else if (ce_i) begin
      jump_q <= 1'b0;
      case (rs_q)
        pxr_pkg::RS_IDLE: begin
          if (rei_i) begin
            rs_q   <= pxr_pkg::RS_JUMP;
            jump_q <= 1'b1;
            tgt_q  <= {exc_ret_q[63:2], 2'h0};
            fwm_q  <= exc_ret_q[pxr_pkg::FW_MODE_BIT];
          end
        end
        pxr_pkg::RS_JUMP: begin
          rs_q <= pxr_pkg::RS_WAIT;
        end
        pxr_pkg::RS_WAIT: begin
          if (!rei_i) begin
            rs_q <= pxr_pkg::RS_IDLE;
          end
        end
        default: begin
          rs_q <= pxr_pkg::RS_IDLE;
        end
      endcase
    end
  end
  assign rei_jump_o    = jump_q;
  assign rei_target_o  = tgt_q;
  assign rei_fw_mode_o = fwm_q;

  // ****************************************************************
  // interrupt request clear
  // ****************************************************************
  assign clr_wr = mtpr_i && (sel_i == pxr_pkg::SEL_IRQ_CLR);
  // set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_req_q <= 1'b0;
    end else if (ce_i) begin
      if (ser_edge) begin
        ser_req_q <= 1'b1;
      end else if (clr_wr && !wdata_i[pxr_pkg::SER_CLR_BIT]) begin
        ser_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt0_req_q <= 1'b0;
      cnt1_req_q <= 1'b0;
    end else if (ce_i) begin
      if (cnt0_ovf_i) begin
        cnt0_req_q <= 1'b1;
      end else if (clr_wr && !wdata_i[pxr_pkg::CNT0_CLR_BIT]) begin
        cnt0_req_q <= 1'b0;
      end
      if (cnt1_ovf_i) begin
        cnt1_req_q <= 1'b1;
      end else if (clr_wr && !wdata_i[pxr_pkg::CNT1_CLR_BIT]) begin
        cnt1_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_req_q <= 1'b0;
    end else if (ce_i) begin
      if (corr_err_i) begin
        corr_req_q <= 1'b1;
      end else if (clr_wr && !wdata_i[pxr_pkg::CORR_CLR_BIT]) begin
        corr_req_q <= 1'b0;
      end
    end
  end
  assign ser_req_o  = ser_req_q;
  assign cnt0_req_o = cnt0_req_q;
  assign cnt1_req_o = cnt1_req_q;
  assign corr_req_o = corr_req_q;
  assign ser_irq_o  = ser_req_q && serial_line_enable_bit_i;

  // ****************************************************************
  // serial receive
  // ****************************************************************
  pxr_ser_rx u_rx (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .ce_i                  (ce_i),
    .loaded_i              (icache_loaded_i),
    .serial_rom_data_pin_i (serial_rom_data_pin_i),
    .rx_lvl_o              (rx_lvl),
    .edge_o                (ser_edge)
  );

  // ****************************************************************
  // translation buffer invalidates
  // ****************************************************************
  // strobes are decoded whatever the mode; firmware keeps the mode discipline
  assign tbi.inv_all = mtpr_i && (sel_i == pxr_pkg::SEL_TB_FULL ||
                                  sel_i == pxr_pkg::SEL_TB_SINGLE);
  assign tbi.inv_nonglobal = mtpr_i && (sel_i == pxr_pkg::SEL_TB_NONGLB);
  assign tbi.fill_valid    = tb_fill_i;
  assign tbi.fill_glob     = tb_fill_glob_i;

  pxr_tb_valid u_tb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .tb    (tbi.arr)
  );
  assign tb_valid_o = tbi.valid;
  assign ptr_rst_o  = tbi.ptr_rst;

  // ****************************************************************
  // current mode
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= pxr_pkg::MODE_RST;
    end else if (ce_i && mtpr_i && sel_i == pxr_pkg::SEL_MODE) begin
      mode_q <= wdata_i[pxr_pkg::CM_WR_LO +: 2];
    end
  end
  assign cur_mode_o = mode_q;

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rd_mux = 64'h0;
    case (sel_i)
      pxr_pkg::SEL_EXC_RET: begin
        rd_mux = exc_ret_q;
      end
      pxr_pkg::SEL_SER_RCV: begin
        rd_mux[pxr_pkg::RX_LVL_BIT] = rx_lvl;
      end
      pxr_pkg::SEL_MODE: begin
        rd_mux[pxr_pkg::CM_RD_LO] = mode_q[0];
        rd_mux[pxr_pkg::CM_RD_HI] = mode_q[1];
      end
      default: begin
        rd_mux = 64'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q  <= 64'h0;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rvalid_q <= mfpr_i;
      if (mfpr_i) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_rei_target;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && rei_i && rs_q == pxr_pkg::RS_IDLE)
      |=> (rei_jump_o && rei_target_o[63:2] == $past(exc_ret_q[63:2]));
  endproperty
  a_rei_target: assert property (p_rei_target) else $error("return target wrong");

  property p_rei_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && rei_i && rs_q == pxr_pkg::RS_IDLE)
      |=> (rei_fw_mode_o == $past(exc_ret_q[0]));
  endproperty
  a_rei_mode: assert property (p_rei_mode) else $error("return mode wrong");

  property p_sw_write;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !exc_i && mtpr_i && sel_i == pxr_pkg::SEL_EXC_RET)
      |=> exc_ret_q == $past(wdata_i);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("return address not written");

  property p_entry_pc;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && exc_i) |=> exc_ret_q[63:2] == $past(exc_pc_i[63:2]);
  endproperty
  a_entry_pc: assert property (p_entry_pc) else $error("entry pc not saved");

  property p_trap_flag;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && exc_i && exc_trap_i) |=> exc_ret_q[1] == $past(exc_adj_ok_i);
  endproperty
  a_trap_flag: assert property (p_trap_flag) else $error("trap adjust flag wrong");

  property p_other_flag;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && exc_i && !exc_trap_i) |=> !exc_ret_q[1];
  endproperty
  a_other_flag: assert property (p_other_flag) else $error("adjust flag set on entry");

  property p_call_pc;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && exc_i && exc_call_i && !exc_trap_i)
      |=> (exc_ret_q[63:2] == $past(exc_pc_i[63:2]) && !exc_ret_q[1]);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call return address wrong");

  property p_ser_clr;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && clr_wr && !wdata_i[pxr_pkg::SER_CLR_BIT] && !ser_edge) |=> !ser_req_q;
  endproperty
  a_ser_clr: assert property (p_ser_clr) else $error("serial request not cleared");

  property p_ones_keep;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && clr_wr && wdata_i[pxr_pkg::CORR_CLR_BIT] && wdata_i[pxr_pkg::CNT0_CLR_BIT]
       && wdata_i[pxr_pkg::CNT1_CLR_BIT] && wdata_i[pxr_pkg::SER_CLR_BIT])
      |=> ($past(corr_req_q) -> corr_req_q) && ($past(cnt0_req_q) -> cnt0_req_q)
          && ($past(cnt1_req_q) -> cnt1_req_q) && ($past(ser_req_q) -> ser_req_q);
  endproperty
  a_ones_keep: assert property (p_ones_keep) else $error("request lost on one write");

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i)
      !serial_line_enable_bit_i |-> !ser_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("serial irq while disabled");

  property p_inv_all;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mtpr_i && sel_i == pxr_pkg::SEL_TB_SINGLE)
      |=> (tb_valid_o == 12'h000 && ptr_rst_o == 2'h3);
  endproperty
  a_inv_all: assert property (p_inv_all) else $error("single invalidate incomplete");

  property p_mode_rd;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mfpr_i && sel_i == pxr_pkg::SEL_MODE)
      |=> (rdata_o == {29'h0, $past(mode_q[1]), 32'h0, $past(mode_q[0]), 1'b0});
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read format wrong");

endmodule : pxr_regs

// ---- verif/pxr_regs_tb_top.sv ----
/*
  pxr_regs_tb_top: self-checking bench for the exception and mode register bank.
  assumes: pxr_pkg is compiled first; the bench drives every port of pxr_regs itself.
*/
`timescale 1ns/10ps
module pxr_regs_tb_top;

  // ****************************************************************
  // ports, reference model and counters
  // ****************************************************************
  logic        clk_i = 1'b0;
  logic        rst_i, ce_i, mtpr_i, mfpr_i, rvalid_o;
  logic [2:0]  sel_i;
  logic [63:0] wdata_i, rdata_o, exc_pc_i, rei_target_o;
  logic        exc_i, exc_call_i, exc_trap_i, exc_adj_ok_i;
  logic        rei_i, rei_jump_o, rei_fw_mode_o;
  logic        cnt0_ovf_i, cnt1_ovf_i, corr_err_i, serial_line_enable_bit_i;
  logic        ser_req_o, cnt0_req_o, cnt1_req_o, corr_req_o, ser_irq_o;
  logic        icache_loaded_i, serial_rom_data_pin_i;
  logic [11:0] tb_fill_i, tb_fill_glob_i, tb_valid_o;
  logic [1:0]  ptr_rst_o, cur_mode_o;
  logic [63:0] m_ret, seed, r;
  logic [3:0]  m_req;
  logic [11:0] m_valid, m_glob;
  int          n_errors, cmp_count;
  int          clr_pos[4];
  int          inv_sel[4];

  always #25 clk_i = ~clk_i;

  pxr_regs i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mtpr_i(mtpr_i), .mfpr_i(mfpr_i),
    .sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .exc_i(exc_i), .exc_call_i(exc_call_i), .exc_trap_i(exc_trap_i),
    .exc_adj_ok_i(exc_adj_ok_i), .exc_pc_i(exc_pc_i), .rei_i(rei_i),
    .rei_jump_o(rei_jump_o), .rei_target_o(rei_target_o), .rei_fw_mode_o(rei_fw_mode_o),
    .cnt0_ovf_i(cnt0_ovf_i), .cnt1_ovf_i(cnt1_ovf_i), .corr_err_i(corr_err_i),
    .serial_line_enable_bit_i(serial_line_enable_bit_i), .ser_req_o(ser_req_o),
    .cnt0_req_o(cnt0_req_o), .cnt1_req_o(cnt1_req_o), .corr_req_o(corr_req_o),
    .ser_irq_o(ser_irq_o), .icache_loaded_i(icache_loaded_i),
    .serial_rom_data_pin_i(serial_rom_data_pin_i), .tb_fill_i(tb_fill_i),
    .tb_fill_glob_i(tb_fill_glob_i), .tb_valid_o(tb_valid_o), .ptr_rst_o(ptr_rst_o),
    .cur_mode_o(cur_mode_o)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [63:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 7);
    seed = seed ^ (seed << 17);
    return seed;
  endfunction : xs

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // move-to: one strobe cycle, effect lands at the taking edge
  task automatic wr(input logic [2:0] s, input logic [63:0] d);
    @(posedge clk_i);
    mtpr_i  <= 1'b1;
    sel_i   <= s;
    wdata_i <= d;
    @(posedge clk_i);
    mtpr_i  <= 1'b0;
  endtask : wr

  // move-from: data is registered at the taking edge, so look just after that edge
  task automatic rd(input logic [2:0] s, input logic [63:0] exp);
    @(posedge clk_i);
    mfpr_i <= 1'b1;
    sel_i  <= s;
    @(posedge clk_i);
    mfpr_i <= 1'b0;
    #1;
    chk(rvalid_o, 1'b1);
    chk(rdata_o, exp);
  endtask : rd

  task automatic req_chk();
    #1;
    chk({ser_req_o, cnt1_req_o, cnt0_req_o, corr_req_o}, m_req);
  endtask : req_chk

  task automatic exc(input logic call, input logic trap, input logic adj, input logic [63:0] pc);
    @(posedge clk_i);
    exc_i        <= 1'b1;
    exc_call_i   <= call;
    exc_trap_i   <= trap;
    exc_adj_ok_i <= adj;
    exc_pc_i     <= pc;
    @(posedge clk_i);
    exc_i      <= 1'b0;
    exc_call_i <= 1'b0;
    exc_trap_i <= 1'b0;
    m_ret = {pc[63:2], trap & adj, 1'b1};
  endtask : exc

  task automatic rei(input logic [63:0] a);
    wr(pxr_pkg::SEL_EXC_RET, a);
    rd(pxr_pkg::SEL_EXC_RET, a);
    @(posedge clk_i);
    rei_i <= 1'b1;
    @(posedge clk_i);
    rei_i <= 1'b0;
    #1;
    chk(rei_jump_o, 1'b1);
    chk(rei_target_o, {a[63:2], 2'b00});
    chk(rei_fw_mode_o, a[0]);
    @(posedge clk_i);
    #1;
    chk(rei_jump_o, 1'b0);
  endtask : rei

  // fill random entries, then invalidate; the pointer pulse may land in either cycle
  task automatic tb_inv(input logic [2:0] s);
    logic [1:0]  seen_ptr;
    logic [11:0] f;
    logic [11:0] g;
    f = 12'(xs());
    g = 12'(xs());
    @(posedge clk_i);
    tb_fill_i      <= f;
    tb_fill_glob_i <= g;
    @(posedge clk_i);
    tb_fill_i <= 12'h000;
    m_glob  = (m_glob & ~f) | (g & f);
    m_valid = m_valid | f;
    @(posedge clk_i);
    #1;
    chk(tb_valid_o, m_valid);
    wr(s, xs());
    #1;
    seen_ptr = ptr_rst_o;
    @(posedge clk_i);
    #1;
    seen_ptr = seen_ptr | ptr_rst_o;
    m_valid = (s == pxr_pkg::SEL_TB_NONGLB) ? (m_valid & m_glob) : 12'h000;
    chk(tb_valid_o, m_valid);
    chk(seen_ptr, (s == pxr_pkg::SEL_TB_NONGLB) ? 2'h0 : 2'h3);
  endtask : tb_inv

  // ****************************************************************
  // watchdog: the whole sequence needs well under a thousand cycles
  // ****************************************************************
  initial begin
    repeat (4000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 64'h0000_0000_0000_ccef;
    n_errors = 0;
    cmp_count = 0;
    m_req = 4'h0;
    m_valid = 12'h000;
    m_glob = 12'h000;
    clr_pos = '{pxr_pkg::CORR_CLR_BIT, pxr_pkg::CNT0_CLR_BIT, pxr_pkg::CNT1_CLR_BIT,
                pxr_pkg::SER_CLR_BIT};
    inv_sel = '{3, 4, 5, 4};
    rst_i <= 1'b1;
    ce_i <= 1'b1;
    {mtpr_i, mfpr_i, exc_i, exc_call_i, exc_trap_i, exc_adj_ok_i, rei_i} <= 7'h00;
    {cnt0_ovf_i, cnt1_ovf_i, corr_err_i, serial_line_enable_bit_i} <= 4'h0;
    {icache_loaded_i, serial_rom_data_pin_i} <= 2'h0;
    sel_i <= 3'h0;
    wdata_i <= 64'h0;
    exc_pc_i <= 64'h0;
    tb_fill_i <= 12'h000;
    tb_fill_glob_i <= 12'h000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pxr_pkg::SEL_EXC_RET, pxr_pkg::EXC_RET_RST);
    rd(pxr_pkg::SEL_IRQ_CLR, 64'h0);
    rd(pxr_pkg::SEL_SER_RCV, 64'h0);
    rd(pxr_pkg::SEL_MODE, 64'h0);
    for (int i = 0; i < 2; i++) begin
      rei((xs() & ~64'h1) | 64'(i[0]));
    end
    for (int i = 0; i < 4; i++) begin
      exc(i == 1, i >= 2, i == 3, xs());
      rd(pxr_pkg::SEL_EXC_RET, m_ret);
    end
    // firmware side fix-up of a four-high trap address before returning
    exc(1'b0, 1'b1, 1'b0, xs());
    rei((m_ret - pxr_pkg::PC_STEP) & ~64'h2);
    // serial receive: nothing before a transition, then one toggle
    icache_loaded_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    req_chk();
    @(posedge clk_i);
    serial_rom_data_pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    m_req[3] = 1'b1;
    req_chk();
    chk(ser_irq_o, 1'b0);
    rd(pxr_pkg::SEL_SER_RCV, 64'h1 << pxr_pkg::RX_LVL_BIT);
    @(posedge clk_i);
    serial_line_enable_bit_i <= 1'b1;
    #1;
    chk(ser_irq_o, 1'b1);
    @(posedge clk_i);
    {cnt0_ovf_i, cnt1_ovf_i, corr_err_i} <= 3'h7;
    @(posedge clk_i);
    {cnt0_ovf_i, cnt1_ovf_i, corr_err_i} <= 3'h0;
    m_req = 4'hf;
    @(posedge clk_i);
    req_chk();
    wr(pxr_pkg::SEL_IRQ_CLR, ~64'h0);
    req_chk();
    r = xs() | (64'h1 << 32) | 64'h8101;
    wr(pxr_pkg::SEL_IRQ_CLR, r);
    req_chk();
    rd(pxr_pkg::SEL_IRQ_CLR, 64'h0);
    for (int i = 0; i < 4; i++) begin
      wr(pxr_pkg::SEL_IRQ_CLR, ~(64'h1 << clr_pos[i]));
      m_req[i] = 1'b0;
      req_chk();
    end
    chk(ser_irq_o, 1'b0);
    // falling transition on the pin must raise the request as well
    serial_rom_data_pin_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    m_req[3] = 1'b1;
    req_chk();
    chk(ser_irq_o, 1'b1);
    rd(pxr_pkg::SEL_SER_RCV, 64'h0);
    for (int i = 0; i < 4; i++) begin
      r = (xs() & ~64'h18) | (64'(i) << 3);
      wr(pxr_pkg::SEL_MODE, r);
      rd(pxr_pkg::SEL_MODE, (64'(r[4]) << 34) | (64'(r[3]) << 1));
      chk(cur_mode_o, r[4:3]);
    end
    // a frozen clock enable must drop the move
    ce_i <= 1'b0;
    wr(pxr_pkg::SEL_MODE, 64'h0);
    #1;
    chk(cur_mode_o, r[4:3]);
    @(posedge clk_i);
    ce_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tb_inv(inv_sel[i][2:0]);
    end
    complete_run();
  end

endmodule : pxr_regs_tb_top
